// ===== design/ohp_ports.sv
`timescale 1ns/1ns
// Operation
// - received overhead bits shift out unaligned, changing on falling receive bit clock
// - transmit overhead bits taken only while external bit select is one
// - transmit overhead bits sampled on rising edges of transmit bit clock
// - all nine received path overhead bytes shift out on falling clock edges
// - receive frame pulse is one clock cycle high, at the J1 byte
// - the same receive frame pulse marks the alarm output frame
// - receive path overhead clock paces byte output and alarm output
// - J1, C2, G1, F2, H4, F3, K4, N1 sampled on rising transmit clock
// - bit times of the B3 byte on the transmit input are ignored
// - transmit frame pulse is one clock cycle high at start of J1
// - device generates the gapped transmit path overhead clock
// - alarm pattern repeats each eight bits: rei count, rdi, then zeros
module ohp_ports
   import ohp_pkg::*;
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   // configuration
   input  wire logic                   external_obit_select,
   // received overhead bits from the mapper
   input  wire logic                   rx_obit_in_valid,
   input  wire logic                   rx_obit_in_bit,
   output logic                        rx_obit_in_ready,
   // receive overhead bit pins
   output logic                        rx_obit_clock,
   output logic                        rx_obit_data,
   // transmit overhead bit pins
   output logic                        tx_obit_clock,
   input  wire logic                   tx_obit_data,
   // transmit overhead bits to the mapper
   output logic                        tx_obit_out_valid,
   output logic                        tx_obit_out_bit,
   // received path overhead and alarm state from the mapper
   input  wire logic [POH_BITS-1:0]    rx_poh_bytes,
   input  wire logic [REI_W-1:0]       rx_rei_count,
   input  wire logic                   rx_rdi,
   // receive path overhead pins
   output logic                        rx_poh_gapped_clock,
   output logic                        rx_poh_serial_data,
   output logic                        rx_poh_frame_pulse,
   output logic                        rx_alarm_port_data,
   // transmit path overhead pins
   output logic                        tx_poh_gapped_clock,
   input  wire logic                   tx_poh_serial_data,
   output logic                        tx_poh_frame_pulse,
   // transmit path overhead to the mapper
   output logic [POH_BITS-1:0]         tx_poh_bytes,
   output logic                        tx_poh_valid
);

   // picks bit idx of a byte string, msb of the first byte at idx zero
   function automatic logic poh_bit(input logic [POH_BITS-1:0] bytes,
                                    input logic [POH_IDX_W-1:0] idx);
      poh_bit = bytes[POH_LAST_IDX - idx];
   endfunction : poh_bit

   // next position in the 72-bit cycle
   function automatic logic [POH_IDX_W-1:0] next_idx(input logic [POH_IDX_W-1:0] idx);
      next_idx = (idx == POH_LAST_IDX) ? POH_FIRST_IDX : POH_IDX_W'(idx + 7'h01);
   endfunction : next_idx

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // gapped clock generators
   ohp_gap_if obit_gap ();
   ohp_gap_if poh_gap ();

   ohp_gapclk #(
      .HALF   (OBIT_HALF),
      .SLOTS  (OBIT_SLOTS),
      .ACTIVE (OBIT_ACTIVE)
   ) u_obit_clk (
      .mclk  (mclk),
      .rst_n (rst_n),
      .gap   (obit_gap)
   );

   ohp_gapclk #(
      .HALF   (POH_HALF),
      .SLOTS  (POH_SLOTS),
      .ACTIVE (POH_BITS)
   ) u_poh_clk (
      .mclk  (mclk),
      .rst_n (rst_n),
      .gap   (poh_gap)
   );

   // both bit clocks share one gapped pattern, both overhead clocks another
   assign rx_obit_clock       = obit_gap.clk;
   assign tx_obit_clock       = obit_gap.clk;
   assign rx_poh_gapped_clock = poh_gap.clk;
   assign tx_poh_gapped_clock = poh_gap.clk;

   a_rx_obit_high: assert property ($rose(rx_obit_clock) |-> rx_obit_clock[*7] ##1 !rx_obit_clock)
      else $error("receive bit clock high time wrong");
   a_tx_obit_gap: assert property ($fell(tx_obit_clock) |-> !tx_obit_clock[*8])
      else $error("transmit bit clock gap too short");

   // ---------------- receive overhead bits ----------------
   logic fifo_valid;
   logic fifo_bit;
   logic rx_obit_r;

   ohp_fifo #(
      .W     (OBIT_FIFO_W),
      .DEPTH (OBIT_FIFO_D)
   ) u_obit_fifo (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_valid  (rx_obit_in_valid),
      .in_data   (rx_obit_in_bit),
      .in_ready  (rx_obit_in_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_bit),
      .out_ready (obit_gap.fall)
   );

   // next buffered bit goes out on each falling edge, zero when starved
   always_ff @(posedge mclk) begin
      if (!rst_n)
         rx_obit_r <= 1'b0;
      else if (obit_gap.fall)
         rx_obit_r <= fifo_valid ? fifo_bit : 1'b0;
   end

   assign rx_obit_data = rx_obit_r;

   a_rx_obit_edge: assert property ($changed(rx_obit_data) |-> $past(obit_gap.fall))
      else $error("receive bit changed off a falling edge");

   // ---------------- transmit overhead bits ----------------
   logic tx_obit_s1_r;
   logic tx_obit_s2_r;
   logic tx_obit_vld_r;
   logic tx_obit_bit_r;

   // two-stage synchroniser for the bit pin
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_obit_s1_r <= 1'b0;
         tx_obit_s2_r <= 1'b0;
      end else begin
         tx_obit_s1_r <= tx_obit_data;
         tx_obit_s2_r <= tx_obit_s1_r;
      end
   end

   // sample on each rising edge while external insertion is selected
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_obit_vld_r <= 1'b0;
         tx_obit_bit_r <= 1'b0;
      end else begin
         tx_obit_vld_r <= obit_gap.rise && external_obit_select;
         if (obit_gap.rise)
            tx_obit_bit_r <= tx_obit_s2_r;
      end
   end

   // handed on as a plain stream, no position attached
   assign tx_obit_out_valid = tx_obit_vld_r;
   assign tx_obit_out_bit   = tx_obit_bit_r;

   a_tx_obit_gate: assert property (tx_obit_out_valid |-> $past(external_obit_select))
      else $error("transmit bit taken while deselected");
   a_tx_obit_rise: assert property (tx_obit_out_valid |-> $past(obit_gap.rise))
      else $error("transmit bit taken off a rising edge");

   // ---------------- receive path overhead and alarm ----------------
   logic [POH_IDX_W-1:0] rx_idx_r;
   logic [POH_IDX_W-1:0] rx_idx_nxt;
   logic [POH_BITS-1:0]  rx_shadow_r;
   logic [ALM_BITS-1:0]  alm_shadow_r;
   logic [ALM_BITS-1:0]  alm_now;
   logic                 rx_data_r;
   logic                 rx_frame_r;
   logic                 alm_data_r;

   assign rx_idx_nxt = next_idx(rx_idx_r);
   assign alm_now    = {rx_rei_count, rx_rdi, ALM_PAD'(0)};

   // frame pulses rise three mclk cycles ahead of the J1 msb rising edge, not at the burst end
   localparam int FRAME_LEAD = (POH_SLOTS - POH_BITS) * 2 * POH_HALF;
   logic [9:0] lead_r;
   logic       lead_hit;

   assign lead_hit = (lead_r == 10'(FRAME_LEAD));

   // counts mclk from the fall that ends a burst, so the pulse spans one period
   always_ff @(posedge mclk) begin
      if (!rst_n)
         lead_r <= 10'h000;
      else if (poh_gap.fall)
         lead_r <= (rx_idx_nxt == POH_FIRST_IDX) ? 10'h001 : 10'h000;
      else if (lead_r != 10'h000)
         lead_r <= lead_hit ? 10'h000 : 10'(lead_r + 10'h001);
   end

   // receive frame pulse: raised ahead of J1, dropped on the fall that ends J1 msb
   always_ff @(posedge mclk) begin
      if (!rst_n)
         rx_frame_r <= 1'b1;
      else if (lead_hit)
         rx_frame_r <= 1'b1;
      else if (poh_gap.fall)
         rx_frame_r <= 1'b0;
   end

   // bit position of what is on the pins, moved on each falling edge
   always_ff @(posedge mclk) begin
      if (!rst_n)
         rx_idx_r <= POH_FIRST_IDX;
      else if (poh_gap.fall)
         rx_idx_r <= rx_idx_nxt;
   end

   // snapshot of the bytes and alarm state at the frame start
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_shadow_r  <= '0;
         alm_shadow_r <= '0;
      end else if (poh_gap.fall && rx_idx_nxt == POH_FIRST_IDX) begin
         rx_shadow_r  <= rx_poh_bytes;
         alm_shadow_r <= alm_now;
      end
   end

   // data and alarm change together on falling edges
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_data_r  <= 1'b0;
         alm_data_r <= 1'b0;
      end else if (poh_gap.fall) begin
         if (rx_idx_nxt == POH_FIRST_IDX) begin
            rx_data_r  <= poh_bit(rx_poh_bytes, rx_idx_nxt);
            alm_data_r <= alm_now[ALM_BITS-1];
         end else begin
            rx_data_r  <= poh_bit(rx_shadow_r, rx_idx_nxt);
            alm_data_r <= alm_shadow_r[3'(ALM_BITS - 1) - rx_idx_nxt[2:0]];
         end
      end
   end

   assign rx_poh_serial_data = rx_data_r;
   assign rx_poh_frame_pulse = rx_frame_r;
   assign rx_alarm_port_data = alm_data_r;

   a_rx_poh_edge: assert property ($changed(rx_poh_serial_data) |-> $past(poh_gap.fall))
      else $error("overhead data changed off a falling edge");
   a_rx_frame_width: assert property ($rose(rx_poh_frame_pulse)
                                      |-> rx_poh_frame_pulse[*8] ##1 !rx_poh_frame_pulse)
      else $error("receive frame pulse not one clock wide");
   a_rx_frame_j1: assert property (rx_poh_frame_pulse |-> rx_idx_r == POH_FIRST_IDX)
      else $error("receive frame pulse off the J1 byte");
   a_alm_edge: assert property ($changed(rx_alarm_port_data) |-> $past(poh_gap.fall))
      else $error("alarm data changed off a falling edge");
   a_alm_pad_zero: assert property (rx_idx_r[2:0] > 3'h4 |-> !rx_alarm_port_data)
      else $error("alarm pad bit not zero");

   // ---------------- transmit path overhead ----------------
   logic                 tx_poh_s1_r;
   logic                 tx_poh_s2_r;
   logic [POH_IDX_W-1:0] tx_idx_r;
   logic [POH_BITS-1:0]  tx_asm_r;
   logic [POH_BITS-1:0]  tx_bytes_r;
   logic                 tx_valid_r;
   logic                 tx_frame_r;
   logic                 tx_in_b3;

   assign tx_in_b3 = (tx_idx_r >= B3_FIRST_IDX) && (tx_idx_r <= B3_LAST_IDX);

   // two-stage synchroniser for the data pin
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_poh_s1_r <= 1'b0;
         tx_poh_s2_r <= 1'b0;
      end else begin
         tx_poh_s1_r <= tx_poh_serial_data;
         tx_poh_s2_r <= tx_poh_s1_r;
      end
   end

   // position of the next bit to sample
   always_ff @(posedge mclk) begin
      if (!rst_n)
         tx_idx_r <= POH_FIRST_IDX;
      else if (poh_gap.rise)
         tx_idx_r <= next_idx(tx_idx_r);
   end

   // assemble bytes on rising edges, the B3 span stays zero
   always_ff @(posedge mclk) begin
      if (!rst_n)
         tx_asm_r <= '0;
      else if (poh_gap.rise)
         tx_asm_r[POH_LAST_IDX - tx_idx_r] <= tx_in_b3 ? 1'b0 : tx_poh_s2_r;
   end

   // complete set handed on after the N1 lsb
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_bytes_r <= '0;
         tx_valid_r <= 1'b0;
      end else begin
         tx_valid_r <= poh_gap.rise && tx_idx_r == POH_LAST_IDX;
         if (poh_gap.rise && tx_idx_r == POH_LAST_IDX) begin
            tx_bytes_r    <= tx_asm_r;
            tx_bytes_r[0] <= tx_poh_s2_r;
         end
      end
   end

   // frame pulse raised on lead_hit, three mclk cycles ahead of the J1 msb rising edge
   always_ff @(posedge mclk) begin
      if (!rst_n)
         tx_frame_r <= 1'b1;
      else if (lead_hit)
         tx_frame_r <= 1'b1;
      else if (poh_gap.fall)
         tx_frame_r <= 1'b0;
   end

   assign tx_poh_bytes       = tx_bytes_r;
   assign tx_poh_valid       = tx_valid_r;
   assign tx_poh_frame_pulse = tx_frame_r;

   a_tx_b3_zero: assert property (tx_poh_valid
                                  |-> tx_poh_bytes[POH_BITS-9:POH_BITS-16] == 8'h00)
      else $error("B3 span not ignored");
   a_tx_frame_j1: assert property (tx_poh_frame_pulse |-> tx_idx_r <= 7'h01)
      else $error("transmit frame pulse off the J1 start");
   a_tx_valid_rise: assert property (tx_poh_valid |-> $past(poh_gap.rise) && tx_idx_r == 7'h00)
      else $error("transmit bytes handed on at wrong time");

endmodule : ohp_ports

// ===== design/ohp_pkg.sv
// shared constants for the overhead serial access ports
package ohp_pkg;

   // system clock
   localparam int CLK_HZ         = 10_000_000;

   // overhead bit clock: burst rate and average rate
   localparam int OBIT_BURST_HZ  = 720_000;
   localparam int OBIT_AVG_HZ    = 144_000;
   // half period in mclk cycles, rounded up
   localparam int OBIT_HALF      = (CLK_HZ + 2 * OBIT_BURST_HZ - 1) / (2 * OBIT_BURST_HZ);
   // one pulse slot in every OBIT_SLOTS slots carries a pulse
   localparam int OBIT_SLOTS     = OBIT_BURST_HZ / OBIT_AVG_HZ;
   localparam int OBIT_ACTIVE    = 1;

   // path overhead clock: burst rate and frame rate
   localparam int POH_BURST_HZ   = 1_250_000;
   localparam int FRAME_HZ       = 8_000;
   localparam int POH_HALF       = (CLK_HZ + 2 * POH_BURST_HZ - 1) / (2 * POH_BURST_HZ);
   localparam int POH_SLOTS      = CLK_HZ / (FRAME_HZ * 2 * POH_HALF);

   // path overhead layout: J1 B3 C2 G1 F2 H4 F3 K4 N1, msb first
   localparam int POH_BYTES      = 9;
   localparam int BYTE_W         = 8;
   localparam int POH_BITS       = POH_BYTES * BYTE_W;
   localparam int POH_IDX_W      = 7;
   localparam logic [6:0] POH_FIRST_IDX = 7'h00;
   localparam logic [6:0] POH_LAST_IDX  = 7'h47;
   localparam logic [6:0] B3_FIRST_IDX  = 7'h08;
   localparam logic [6:0] B3_LAST_IDX   = 7'h0F;

   // alarm indication pattern: rei count, rdi flag, zero fill
   localparam int ALM_BITS       = 8;
   localparam int REI_W          = 4;
   localparam int ALM_PAD        = ALM_BITS - REI_W - 1;

   // receive overhead bit buffer
   localparam int OBIT_FIFO_W    = 1;
   localparam int OBIT_FIFO_D    = 32;

endpackage : ohp_pkg

// ===== design/ohp_gap_if.sv
`timescale 1ns/1ns
// gapped clock level and its edge events, one generator shared by receive and transmit users
interface ohp_gap_if;
   logic clk;
   logic rise;
   logic fall;
   modport gen  (output clk, output rise, output fall);
   modport sink (input clk, input rise, input fall);
endinterface : ohp_gap_if

// ===== design/ohp_gapclk.sv
`timescale 1ns/1ns
// gapped clock: pulses in the first ACTIVE of every SLOTS pulse slots
module ohp_gapclk
   import ohp_pkg::*;
#(
   parameter int HALF   = 4,
   parameter int SLOTS  = 156,
   parameter int ACTIVE = 72
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // generated clock
   ohp_gap_if.gen   gap
);

   logic [7:0] half_r;
   logic       phase_r;
   logic [7:0] slot_r;
   logic       clk_r;
   logic       rise_r;
   logic       fall_r;
   logic       half_end;
   logic       active;

   assign half_end = (half_r == 8'(HALF - 1));
   assign active   = (slot_r < 8'(ACTIVE));

   // half period counter
   always_ff @(posedge mclk) begin
      if (!rst_n)
         half_r <= 8'h00;
      else if (half_end)
         half_r <= 8'h00;
      else
         half_r <= 8'(half_r + 8'h01);
   end

   // low or high half of a slot
   always_ff @(posedge mclk) begin
      if (!rst_n)
         phase_r <= 1'b0;
      else if (half_end)
         phase_r <= ~phase_r;
   end

   // slot position within the gap pattern
   always_ff @(posedge mclk) begin
      if (!rst_n)
         slot_r <= 8'h00;
      else if (half_end && phase_r)
         slot_r <= (slot_r == 8'(SLOTS - 1)) ? 8'h00 : 8'(slot_r + 8'h01);
   end

   // clock level and edge events, rise and fall coincide with the new level
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clk_r  <= 1'b0;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         if (half_end)
            clk_r <= !phase_r && active;
         rise_r <= half_end && !phase_r && active;
         fall_r <= half_end && phase_r && clk_r;
      end
   end

   assign gap.clk  = clk_r;
   assign gap.rise = rise_r;
   assign gap.fall = fall_r;

endmodule : ohp_gapclk

// ===== design/ohp_fifo.sv
`timescale 1ns/1ns
// first-in first-out buffer with valid and ready on both sides
module ohp_fifo
   import ohp_pkg::*;
#(
   parameter int W     = 1,
   parameter int DEPTH = 32,
   parameter int AW    = $clog2(DEPTH)
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // fill side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // drain side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_r;
   logic [AW:0]  rd_r;
   logic         push;
   logic         pop;

   // full when pointers differ only in the wrap bit
   assign in_ready  = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
   assign out_valid = (wr_r != rd_r);
   assign out_data  = mem[rd_r[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage write
   always_ff @(posedge mclk) begin
      if (push)
         mem[wr_r[AW-1:0]] <= in_data;
   end

   // pointers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push)
            wr_r <= (AW+1)'(wr_r + 1'b1);
         if (pop)
            rd_r <= (AW+1)'(rd_r + 1'b1);
      end
   end

endmodule : ohp_fifo

// ===== test/ohp_far_model.sv
`timescale 1ns/1ns
// far-side overhead processor: feeds transmit pins after falls, captures on rises
module ohp_far_model
   import ohp_pkg::*;
#(
   parameter logic [POH_BITS-1:0] TX_PAT   = 72'h0,
   parameter logic [15:0]         OBIT_PAT = 16'h0
) (
   // clock
   input  wire logic mclk,
   // receive pins
   input  wire logic rx_poh_gapped_clock,
   input  wire logic rx_poh_serial_data,
   input  wire logic rx_poh_frame_pulse,
   input  wire logic rx_alarm_port_data,
   input  wire logic rx_obit_clock,
   input  wire logic rx_obit_data,
   // transmit pins
   input  wire logic tx_poh_gapped_clock,
   input  wire logic tx_poh_frame_pulse,
   output logic      tx_poh_serial_data,
   input  wire logic tx_obit_clock,
   output logic      tx_obit_data
);
   wire logic [3:0]     clk_now = {tx_obit_clock, rx_obit_clock,
                                   tx_poh_gapped_clock, rx_poh_gapped_clock};
   logic [3:0]          clk_q   = 4'h0;
   logic [3:0]          rise;
   logic [3:0]          fall;
   logic                fp;
   logic [POH_BITS-1:0] sh_d, sh_f, sh_a, rx_word, rx_frm, rx_alm;
   int                  rx_idx  = 0;
   int                  tx_cnt  = 72;
   int                  ob_k    = 0;
   int                  frames  = 0;
   logic                ob_q[$];

   initial begin
      tx_poh_serial_data = TX_PAT[POH_BITS-1];
      tx_obit_data       = 1'b0;
   end

   // sample the gapped clocks with mclk; levels read here are from before the edge
   always @(posedge mclk) begin
      rise = clk_now & ~clk_q;
      fall = ~clk_now & clk_q;
      if (rise[0]) begin
         if (rx_poh_frame_pulse)
            rx_idx = 0;
         sh_d[71 - rx_idx] = rx_poh_serial_data;
         sh_f[71 - rx_idx] = rx_poh_frame_pulse;
         sh_a[71 - rx_idx] = rx_alarm_port_data;
         if (rx_idx == 71) begin
            rx_word = sh_d;
            rx_frm  = sh_f;
            rx_alm  = sh_a;
            frames++;
         end
         rx_idx = rx_idx + 1;
      end
      if (rise[2])
         ob_q.push_back(rx_obit_data);
      // count transmit bits; a rise seen with the frame pulse high is the j1 msb
      if (rise[1])
         tx_cnt = tx_poh_frame_pulse ? 1 : tx_cnt + 1;
      fp = tx_poh_frame_pulse && !tx_poh_gapped_clock && tx_cnt >= 72;
      clk_q = clk_now;
      #1;
      // new bits go out just after a fall, ready for the next rise
      if (fall[1])
         tx_poh_serial_data = (tx_cnt < 72) ? TX_PAT[71 - tx_cnt] : ~tx_poh_serial_data;
      else if (fp)
         tx_poh_serial_data = TX_PAT[POH_BITS-1];
      if (fall[3]) begin
         tx_obit_data = OBIT_PAT[ob_k % 16];
         ob_k++;
      end
   end
endmodule : ohp_far_model

// ===== test/tb_top.sv
`timescale 1ns/1ns
// self-checking bench for one channel of the overhead serial ports
module tb_top;
   import ohp_pkg::*;
   localparam logic [POH_BITS-1:0] RX_P = 72'h5AC3960FF0A53C817E;
   localparam logic [POH_BITS-1:0] TX_P = 72'hE1D2C3B4A596877869;

   logic                mclk, rst_n, sel, ob_v, ob_b, ob_rdy, rx_oc, rx_od, tx_oc, tx_od;
   logic                tx_ov, tx_ob, rdi, rx_pc, rx_pd, rx_pf, rx_ad, tx_pc, tx_pd, tx_pf;
   logic                tx_pv;
   logic [REI_W-1:0]    rei;
   logic [POH_BITS-1:0] rx_pb, tx_pb;
   int                  miscompares     = 0;
   int                  samples_checked = 0;

   ohp_ports ohp_ports_inst (
      .mclk(mclk), .rst_n(rst_n), .external_obit_select(sel),
      .rx_obit_in_valid(ob_v), .rx_obit_in_bit(ob_b), .rx_obit_in_ready(ob_rdy),
      .rx_obit_clock(rx_oc), .rx_obit_data(rx_od), .tx_obit_clock(tx_oc),
      .tx_obit_data(tx_od), .tx_obit_out_valid(tx_ov), .tx_obit_out_bit(tx_ob),
      .rx_poh_bytes(rx_pb), .rx_rei_count(rei), .rx_rdi(rdi),
      .rx_poh_gapped_clock(rx_pc), .rx_poh_serial_data(rx_pd),
      .rx_poh_frame_pulse(rx_pf), .rx_alarm_port_data(rx_ad),
      .tx_poh_gapped_clock(tx_pc), .tx_poh_serial_data(tx_pd),
      .tx_poh_frame_pulse(tx_pf), .tx_poh_bytes(tx_pb), .tx_poh_valid(tx_pv));

   ohp_far_model #(.TX_PAT(TX_P), .OBIT_PAT(16'hB38E)) ohp_far_model_inst (
      .mclk(mclk), .rx_poh_gapped_clock(rx_pc), .rx_poh_serial_data(rx_pd),
      .rx_poh_frame_pulse(rx_pf), .rx_alarm_port_data(rx_ad), .rx_obit_clock(rx_oc),
      .rx_obit_data(rx_od), .tx_poh_gapped_clock(tx_pc), .tx_poh_frame_pulse(tx_pf),
      .tx_poh_serial_data(tx_pd), .tx_obit_clock(tx_oc), .tx_obit_data(tx_od));

   // system clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // compare and count
   task automatic chk(input logic [POH_BITS-1:0] got, input logic [POH_BITS-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // counts, verdict and end of run
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   // new bytes and alarm state, then two whole frames captured by the far side
   task automatic t_poh_rx(input logic [POH_BITS-1:0] b, input logic [3:0] r, input logic d);
      int f0;
      @(posedge mclk);
      #1;
      rx_pb = b;
      rei   = r;
      rdi   = d;
      f0    = ohp_far_model_inst.frames;
      for (int i = 0; i < 3000 && ohp_far_model_inst.frames < f0 + 2; i++)
         @(posedge mclk);
      chk(ohp_far_model_inst.rx_word, b);
      chk(ohp_far_model_inst.rx_frm, {1'b1, 71'h0});
      chk(ohp_far_model_inst.rx_alm, {9{r, d, 3'h0}});
      $display("test poh receive done");
   endtask : t_poh_rx

   // far side supplies all nine bytes; b3 must come back zero
   task automatic t_poh_tx;
      repeat (2) begin
         for (int i = 0; i < 1400 && tx_pv !== 1'b1; i++)
            @(posedge mclk);
         chk(tx_pb, {TX_P[71:64], 8'h00, TX_P[55:0]});
         @(posedge mclk);
      end
      $display("test poh transmit done");
   endtask : t_poh_tx

   // fill the bit fifo until refused, then let the gapped clock drain it
   task automatic t_obit_rx;
      logic [31:0] pat;
      logic        q;
      logic        tk;
      int          k;
      pat = 32'hC5A19E37;
      q   = 1'b0;
      for (int i = 0; i < 200; i++) begin
         @(posedge mclk);
         if (q === 1'b1 && rx_oc === 1'b0)
            break;
         q = rx_oc;
      end
      repeat (3) @(posedge mclk);
      ohp_far_model_inst.ob_q.delete();
      #1;
      k = 0;
      for (int i = 0; i < 40 && k < 32; i++) begin
         ob_v = 1'b1;
         ob_b = pat[31 - k];
         tk   = ob_rdy;
         @(posedge mclk);
         #1;
         if (tk === 1'b1)
            k++;
      end
      chk(ob_rdy, 1'b0);
      ob_v = 1'b0;
      repeat (36 * 2 * OBIT_HALF * OBIT_SLOTS) @(posedge mclk);
      chk(ohp_far_model_inst.ob_q[0], 1'b0);
      for (int j = 0; j < 32; j++)
         chk(ohp_far_model_inst.ob_q[j + 1], pat[31 - j]);
      chk(ob_rdy, 1'b1);
      $display("test obit receive done");
   endtask : t_obit_rx

   // transmit bits with select high and low; period of the gapped clock
   task automatic t_obit_tx;
      logic q;
      logic e;
      int   n;
      int   k;
      int   lr;
      n  = 0;
      k  = 0;
      lr = -1;
      q  = 1'b0;
      #1;
      sel = 1'b1;
      for (int i = 0; i < 2800; i++) begin
         @(posedge mclk);
         chk(rx_oc, tx_oc);
         if (tx_oc === 1'b1 && q === 1'b0) begin
            e = tx_od;
            if (i < 2100)
               k++;
            if (lr >= 0)
               chk(i - lr, 2 * OBIT_HALF * OBIT_SLOTS);
            lr = i;
         end
         if (tx_ov === 1'b1) begin
            chk(tx_ob, e);
            n++;
         end
         q = tx_oc;
         if (i == 2099) begin
            #1;
            sel = 1'b0;
         end
      end
      chk((n == k) || (n == k + 1), 1'b1);
      $display("test obit transmit done");
   endtask : t_obit_tx

   // watchdog
   initial begin
      repeat (40000) @(posedge mclk);
      miscompares++;
      test_done();
   end

   // main sequence
   initial begin
      rst_n = 1'b0;
      sel   = 1'b0;
      ob_v  = 1'b0;
      ob_b  = 1'b0;
      rei   = 4'h0;
      rdi   = 1'b0;
      rx_pb = RX_P;
      repeat (6) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      t_poh_rx(RX_P, 4'hA, 1'b1);
      t_poh_rx(~RX_P, 4'h5, 1'b0);
      t_poh_tx();
      t_obit_rx();
      t_obit_tx();
      test_done();
   end
endmodule : tb_top
